// ===== design/haptic_status_control_consts.svh
// register offsets, field positions, reset values and timing counts of the haptic status/control bank
// assumes a 16-bit register address with one data byte per address
`ifndef HAPTIC_STATUS_CONTROL_CONSTS_SVH
`define HAPTIC_STATUS_CONTROL_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_SYSTEM_STATUS        16'h1000
`define OFS_SYSTEM_SETTINGS      16'h2000
`define OFS_THERMAL_TRIP         16'h2001
`define OFS_SYSTEM_CONTROL       16'h2002
`define OFS_HAPTIC_CONTROL       16'h2003

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define STS_OVER_TEMP_BIT        5
`define STS_OVER_CURR_BIT        4
`define STS_DEEP_SLEEP_BIT       3
`define STS_RECAL_BIT            2
`define STS_ACTIVE_BIT           1
`define STS_RESET_BIT            0

// ----------------------------------------------------------------
// settings and control field positions
// ----------------------------------------------------------------
`define SET_TRIG_MODE_BIT        6
`define SET_TIMEOUT_LSB          2
`define SET_TIMEOUT_MSB          5
`define SET_PMODE_LSB            0
`define SET_PMODE_MSB            1
`define OT_HYST_BIT              4
`define OT_THRESH_LSB            0
`define OT_THRESH_MSB            3
`define SYS_SOFT_RESET_BIT       1
`define SYS_ACK_RESET_BIT        0
`define HAP_STOP_BIT             1
`define HAP_TRIGGER_BIT          0

// ----------------------------------------------------------------
// reset values, masks and fixed answers
// ----------------------------------------------------------------
`define SETTINGS_RESET           8'h22
`define THERMAL_RESET            8'h1A
`define SETTINGS_MASK            8'h7F
`define THERMAL_MASK             8'h1F
`define UNMAPPED_READ            8'hEE

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ                   50000000
`define MS_PER_TIMEOUT_STEP      512
`define CYCLES_PER_MS            (`CLK_HZ / 1000)

`endif

// ===== design/haptic_status_control_pkg.sv
// types shared by the haptic status/control bank and its power-state controller
// assumes nothing beyond the consts header for numbers
package haptic_status_control_pkg;

  // power behaviour selected by software
  typedef enum logic [1:0] {
    PMODE_FAST = 2'h0,
    PMODE_DEEP = 2'h1,
    PMODE_AUTO = 2'h2,
    PMODE_RSVD = 2'h3
  } power_mode_e;

  // present power state of the device
  typedef enum logic {
    PSTATE_FAST,
    PSTATE_DEEP
  } power_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ===== design/power_ctrl_if.sv
// carrier between the register bank and the power-state controller
// assumes both ends share clk_i and rst_i
`timescale 1ns/1ps
interface power_ctrl_if;
  import haptic_status_control_pkg::*;

  power_mode_e mode;         // software power behaviour
  logic [3:0]  timeout_field; // idle timeout in 512 ms steps
  logic        busy;          // engine playing or trigger pending
  logic        deep_sleep;    // 1 while in the deep_sleep_state

  modport bank (output mode, output timeout_field, output busy, input deep_sleep);
  modport ctrl (input mode, input timeout_field, input busy, output deep_sleep);
endinterface

// ===== design/power_state_ctrl.sv
// power-state controller: picks fast or deep_sleep_state from the software mode and idle time
// assumes one clock, asynchronous active-high reset and a clock enable
`timescale 1ns/1ps
`include "haptic_status_control_consts.svh"
module power_state_ctrl
  import haptic_status_control_pkg::*;
#(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  ce_i,
  power_ctrl_if.ctrl pm
);

  // ----------------------------------------------------------------
  // millisecond tick and idle time
  // ----------------------------------------------------------------
  logic [31:0]  cyc_reg;
  logic [12:0]  ms_reg;
  logic         tick;
  logic [12:0]  limit;

  assign tick  = (cyc_reg == 32'(CYCLES_PER_MS - 1));
  assign limit = 13'(pm.timeout_field) * 13'(`MS_PER_TIMEOUT_STEP);

  // idle time restarts on any activity, so the timeout measures quiet time only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_reg <= 32'h0;
      ms_reg  <= 13'h0;
    end else if (ce_i) begin
      if (pm.busy || pm.mode != PMODE_AUTO) begin
        cyc_reg <= 32'h0;
        ms_reg  <= 13'h0;
      end else if (tick) begin
        cyc_reg <= 32'h0;
        if (ms_reg != 13'h1FFF) begin
          ms_reg <= ms_reg + 13'h1;
        end
      end else begin
        cyc_reg <= cyc_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  power_state_e state_reg;

  // automatic mode wakes on activity and sleeps after the idle timeout
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PSTATE_FAST;
    end else if (ce_i) begin
      case (pm.mode)
        PMODE_FAST: state_reg <= PSTATE_FAST;
        PMODE_DEEP: state_reg <= PSTATE_DEEP;
        PMODE_AUTO: begin
          if (pm.busy) begin
            state_reg <= PSTATE_FAST;
          end else if (ms_reg >= limit) begin
            state_reg <= PSTATE_DEEP;
          end
        end
        default: state_reg <= PSTATE_FAST; // unlisted code behaves as fast
      endcase
    end
  end

  assign pm.deep_sleep = (state_reg == PSTATE_DEEP);

endmodule

// ===== design/haptic_status_control_regs.sv
// status and control register bank of the haptic driver, reached by byte address over the host link
// assumes the link engine presents one-cycle read/write strobes with a 16-bit address
// and that fault events and engine activity already arrive synchronous to clk_i
//
// Function
// - status bit 5 sets on over-temperature, clears when status is read.
// - status bit 4 sets on over-current, clears when status is read.
// - status bit 3 reads 0 in fast state, 1 in deep_sleep_state.
// - status bit 1 reads 1 while the haptic engine plays.
// - status bit 0 reads 1 while a reset condition is flagged.
// - settings bit 6 picks edge (0) or level (1) triggering.
// - settings bits 5:2 give power timeout of 512 ms per step.
// - settings bits 1:0 pick fast, deep-sleep or automatic power behaviour.
// - thermal bit 4 enables hysteresis; bits 3:0 pick trip threshold.
// - writing 1 to system control bit 1 soft-resets; 0 does nothing.
// - writing 1 to system control bit 0 acknowledges reset; self-clears.
// - writing 1 to haptic control bit 1 stops playback; self-clears.
// - writing 1 to haptic control bit 0 starts playback; self-clears.
`timescale 1ns/1ps
`include "haptic_status_control_consts.svh"
module haptic_status_control_regs
  import haptic_status_control_pkg::*;
#(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // register access from the link engine
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // events and state from the drive side
  input  wire logic        over_temp_evt_i,
  input  wire logic        over_curr_evt_i,
  input  wire logic        haptics_active_i,
  input  wire logic        recal_hint_i,
  // settings towards the drive side
  output logic             trigger_level_mode_o,
  output logic      [1:0]  power_mode_o,
  output logic      [3:0]  power_timeout_o,
  output logic             hysteresis_en_o,
  output logic      [3:0]  temp_threshold_o,
  output logic             deep_sleep_state_o,
  // one-cycle action pulses
  output logic             soft_reset_o,
  output logic             trigger_o,
  output logic             stop_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_set;
  logic wr_thm;
  logic wr_sys;
  logic wr_hap;
  logic rd_sts;

  // every strobe is gated by the clock enable, so a frozen bank ignores the host
  assign wr_set = ce_i && reg_wr_i && hit(reg_addr_i, `OFS_SYSTEM_SETTINGS);
  assign wr_thm = ce_i && reg_wr_i && hit(reg_addr_i, `OFS_THERMAL_TRIP);
  assign wr_sys = ce_i && reg_wr_i && hit(reg_addr_i, `OFS_SYSTEM_CONTROL);
  assign wr_hap = ce_i && reg_wr_i && hit(reg_addr_i, `OFS_HAPTIC_CONTROL);
  assign rd_sts = ce_i && reg_rd_i && hit(reg_addr_i, `OFS_SYSTEM_STATUS);

  // ----------------------------------------------------------------
  // action strobes
  // ----------------------------------------------------------------
  logic soft_rst_req;
  logic ack_req;

  assign soft_rst_req = wr_sys && reg_wdata_i[`SYS_SOFT_RESET_BIT];
  assign ack_req      = wr_sys && reg_wdata_i[`SYS_ACK_RESET_BIT];

  // action bits never store; the read mux answers zero for both control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
      trigger_o    <= 1'b0;
      stop_o       <= 1'b0;
    end else if (ce_i) begin
      soft_reset_o <= soft_rst_req;
      // stop beats trigger when both bits arrive in one byte
      stop_o       <= wr_hap && reg_wdata_i[`HAP_STOP_BIT];
      trigger_o    <= wr_hap && reg_wdata_i[`HAP_TRIGGER_BIT]
                      && !reg_wdata_i[`HAP_STOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  byte_t settings_reg;
  byte_t thermal_reg;

  // a soft reset brings the settings back to their power-on values
  // masks drop reserved bits on the way in, so read-back needs no extra gating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settings_reg <= `SETTINGS_RESET;
      thermal_reg  <= `THERMAL_RESET;
    end else if (ce_i) begin
      if (soft_rst_req) begin
        settings_reg <= `SETTINGS_RESET;
        thermal_reg  <= `THERMAL_RESET;
      end else begin
        if (wr_set) begin
          settings_reg <= reg_wdata_i & `SETTINGS_MASK;
        end
        if (wr_thm) begin
          thermal_reg <= reg_wdata_i & `THERMAL_MASK;
        end
      end
    end
  end

  assign trigger_level_mode_o = settings_reg[`SET_TRIG_MODE_BIT];
  assign power_timeout_o      = settings_reg[`SET_TIMEOUT_MSB:`SET_TIMEOUT_LSB];
  assign power_mode_o         = settings_reg[`SET_PMODE_MSB:`SET_PMODE_LSB];
  assign hysteresis_en_o      = thermal_reg[`OT_HYST_BIT];
  assign temp_threshold_o     = thermal_reg[`OT_THRESH_MSB:`OT_THRESH_LSB];

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  logic over_temp_reg;
  logic over_curr_reg;
  logic reset_flag_reg;

  // sticky next value: a new event always beats the clear in the same cycle,
  // so a fault that races a status read shows on the next read instead of being lost
  function automatic logic sticky_next(input logic evt, input logic flag, input logic clr);
    sticky_next = evt || (flag && !clr);
  endfunction

  // a fault that lands in the reading cycle survives the clear-on-read
  // soft reset leaves the fault flags alone so the fault that caused it stays visible
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      over_temp_reg <= 1'b0;
      over_curr_reg <= 1'b0;
    end else if (ce_i) begin
      over_temp_reg <= sticky_next(over_temp_evt_i, over_temp_reg, rd_sts);
      over_curr_reg <= sticky_next(over_curr_evt_i, over_curr_reg, rd_sts);
    end
  end

  // reset flag comes up set after power-on and soft reset alike
  // acknowledge and soft reset in one byte leave the flag set: the soft reset wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_flag_reg <= 1'b1;
    end else if (ce_i) begin
      reset_flag_reg <= sticky_next(soft_rst_req, reset_flag_reg, ack_req);
    end
  end

  // ----------------------------------------------------------------
  // power-state controller
  // ----------------------------------------------------------------
  // the controller owns the idle timer; this bank only supplies mode, timeout and activity
  // busy counts the trigger pulse too, so automatic mode wakes before the engine reports activity
  power_ctrl_if pm_bus ();

  assign pm_bus.mode          = power_mode_e'(power_mode_o);
  assign pm_bus.timeout_field = power_timeout_o;
  assign pm_bus.busy          = haptics_active_i || trigger_o;
  assign deep_sleep_state_o   = pm_bus.deep_sleep;

  power_state_ctrl #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_power (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .pm    (pm_bus)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // bit 2 passes the drive side's recalibrate hint straight through
  // reserved bits 7:6 stay zero so software can compare whole bytes safely
  byte_t status_val;

  always_comb begin
    status_val                      = 8'h00;
    status_val[`STS_OVER_TEMP_BIT]  = over_temp_reg;
    status_val[`STS_OVER_CURR_BIT]  = over_curr_reg;
    status_val[`STS_DEEP_SLEEP_BIT] = pm_bus.deep_sleep;
    status_val[`STS_RECAL_BIT]      = recal_hint_i;
    status_val[`STS_ACTIVE_BIT]     = haptics_active_i;
    status_val[`STS_RESET_BIT]      = reset_flag_reg;
  end

  // data is held until the next read; unmapped addresses answer a fixed byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        `OFS_SYSTEM_STATUS:   reg_rdata_o <= status_val;
        `OFS_SYSTEM_SETTINGS: reg_rdata_o <= settings_reg;
        `OFS_THERMAL_TRIP:    reg_rdata_o <= thermal_reg;
        `OFS_SYSTEM_CONTROL:  reg_rdata_o <= 8'h00;  // self-clearing
        `OFS_HAPTIC_CONTROL:  reg_rdata_o <= 8'h00;  // self-clearing
        default:              reg_rdata_o <= `UNMAPPED_READ;
      endcase
    end
  end

endmodule

// ===== test/host_model.sv
// host-side register master standing where the link engine would, one byte per strobe
// assumes clk_i is the bank clock; strobes change only just after rising edges
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_i,
  output logic      [15:0] reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [7:0]  reg_wdata_o,
  input  wire logic [7:0]  reg_rdata_i
);
  initial begin
    reg_addr_o  = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one strobe cycle; address and data are inverted afterwards so stale values never pass as live
  task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= w;
    reg_rd_o    <= ~w;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_rd_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
    #1 q = reg_rdata_i;
  endtask
endmodule

// ===== test/haptic_regs_monitor.sv
// concurrent checks on the ports of the haptic status/control bank
// assumes one clock domain; bound into every bank instance
`timescale 1ns/1ps
module haptic_regs_monitor #(
  parameter int CYCLES_PER_MS = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        over_temp_evt_i,
  input wire logic        over_curr_evt_i,
  input wire logic        haptics_active_i,
  input wire logic        recal_hint_i,
  input wire logic        trigger_level_mode_o,
  input wire logic [1:0]  power_mode_o,
  input wire logic [3:0]  power_timeout_o,
  input wire logic        hysteresis_en_o,
  input wire logic [3:0]  temp_threshold_o,
  input wire logic        deep_sleep_state_o,
  input wire logic        soft_reset_o,
  input wire logic        trigger_o,
  input wire logic        stop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // decoded accesses
  // ----
  wire rd_sts = ce_i && reg_rd_i && reg_addr_i == 16'h1000;
  wire rd_any = ce_i && reg_rd_i;
  wire wr_any = ce_i && reg_wr_i;
  wire quiet  = !over_temp_evt_i && !over_curr_evt_i;  // no fault event racing the read
  wire mapped = reg_addr_i == 16'h1000 || (reg_addr_i >= 16'h2000 && reg_addr_i <= 16'h2003);
  wire [6:0] set_out = {trigger_level_mode_o, power_timeout_o, power_mode_o};
  wire [4:0] thr_out = {hysteresis_en_o, temp_threshold_o};
  a_ot_flag_set: assert property (ce_i && over_temp_evt_i ##1 !rd_sts ##1 rd_sts |=> reg_rdata_o[5])
    else $error("over-temperature flag missing on status read");
  a_oc_flag_set: assert property (ce_i && over_curr_evt_i ##1 !rd_sts ##1 rd_sts |=> reg_rdata_o[4])
    else $error("over-current flag missing on status read");
  a_flags_clear_read: assert property ((rd_sts && quiet) ##1 quiet ##1 (rd_sts && quiet) |=>
    reg_rdata_o[5:4] == 2'b00)
    else $error("fault flags survived a status read");
  a_status_live: assert property (rd_sts |=> reg_rdata_o[7:6] == 2'b00 &&
    reg_rdata_o[3] == $past(deep_sleep_state_o) && reg_rdata_o[1] == $past(haptics_active_i))
    else $error("status live bits wrong");
  a_unmapped_read: assert property (rd_any && !mapped |=> reg_rdata_o == 8'hEE)
    else $error("unmapped read not 0xEE");
  a_ctrl_reads_zero: assert property (rd_any && reg_addr_i[15:1] == 15'h1001 |=> reg_rdata_o == 8'h00)
    else $error("control register did not read zero");
  a_trig_pulse: assert property (wr_any && reg_addr_i == 16'h2003 && reg_wdata_i[1:0] == 2'b01 |=>
    trigger_o && !stop_o)
    else $error("trigger pulse missing");
  a_stop_pulse: assert property (wr_any && reg_addr_i == 16'h2003 && reg_wdata_i[1] |=> stop_o && !trigger_o)
    else $error("stop pulse missing");
  a_no_idle_pulse: assert property (!(wr_any && reg_addr_i == 16'h2003) |=> !trigger_o && !stop_o)
    else $error("action pulse without a write");
  a_soft_reset: assert property (wr_any && reg_addr_i == 16'h2002 && reg_wdata_i[1] |=>
    soft_reset_o && set_out == 7'h22 && thr_out == 5'h1A)
    else $error("soft reset did not restore settings");
  a_settings_wr: assert property (wr_any && reg_addr_i == 16'h2000 |=>
    {1'b0, set_out} == ($past(reg_wdata_i) & 8'h7F))
    else $error("settings outputs do not follow write");
  a_thermal_wr: assert property (wr_any && reg_addr_i == 16'h2001 |=>
    {3'b000, thr_out} == ($past(reg_wdata_i) & 8'h1F))
    else $error("thermal outputs do not follow write");
  a_fixed_mode: assert property (!power_mode_o[1] ##1 $stable(power_mode_o) |->
    deep_sleep_state_o == power_mode_o[0])
    else $error("power state does not follow fixed mode");
  a_auto_sleep: assert property (ce_i && power_mode_o == 2'h2 && power_timeout_o == 4'h0 &&
    !haptics_active_i && !trigger_o |=> deep_sleep_state_o)
    else $error("automatic mode with zero timeout did not sleep");
  a_auto_wake: assert property (ce_i && power_mode_o == 2'h2 && haptics_active_i |=> !deep_sleep_state_o)
    else $error("automatic mode did not wake on activity");
endmodule
bind haptic_status_control_regs haptic_regs_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) mon (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .over_temp_evt_i(over_temp_evt_i), .over_curr_evt_i(over_curr_evt_i), .haptics_active_i(haptics_active_i),
  .recal_hint_i(recal_hint_i), .trigger_level_mode_o(trigger_level_mode_o), .power_mode_o(power_mode_o),
  .power_timeout_o(power_timeout_o), .hysteresis_en_o(hysteresis_en_o), .temp_threshold_o(temp_threshold_o),
  .deep_sleep_state_o(deep_sleep_state_o), .soft_reset_o(soft_reset_o), .trigger_o(trigger_o), .stop_o(stop_o)
);

// ===== test/testbench.sv
// self-checking bench: host model drives the bank, an integer model predicts every read and output
// assumes a 50 MHz clock and a millisecond shortened to 4 cycles
`timescale 1ns/1ps
module testbench;
  import haptic_status_control_pkg::*;
  localparam int CPM = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, ot_i = 1'b0, oc_i = 1'b0, act_i = 1'b0, recal_i = 1'b0, ce_i = 1'b1;
  logic [15:0] addr;
  logic        wr, rd, tlm, hyst, deep, srst, trig, stop;
  logic [7:0]  wdata, rdata, q, d;
  logic [1:0]  pmode;
  logic [3:0]  ptmo, thr;
  logic [7:0]  hc [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFD};
  int set_m = 'h22, thr_m = 'h1A, ot_m = 0, oc_m = 0, rf_m = 1, bad_count = 0, n_compared = 0, cyc = 0;
  integer seed = 73;
  initial forever #10 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata));
  haptic_status_control_regs #(.CYCLES_PER_MS(CPM)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .over_temp_evt_i(ot_i), .over_curr_evt_i(oc_i), .haptics_active_i(act_i), .recal_hint_i(recal_i),
    .trigger_level_mode_o(tlm), .power_mode_o(pmode), .power_timeout_o(ptmo), .hysteresis_en_o(hyst),
    .temp_threshold_o(thr), .deep_sleep_state_o(deep), .soft_reset_o(srst), .trigger_o(trig), .stop_o(stop));
  // ----
  // checking helpers
  // ----
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrr(input logic [15:0] a, input logic [7:0] v);
    host.access(a, 1'b1, v, q);
  endtask
  task automatic rdr(input logic [15:0] a);
    host.access(a, 1'b0, 8'h00, q);
  endtask
  // a status read clears both fault flags in the model as well
  task automatic rd_sts(input logic dp);
    rdr(16'h1000);
    chk("status", {2'b00, ot_m[0], oc_m[0], dp, recal_i, act_i, rf_m[0]}, q);
    ot_m = 0;
    oc_m = 0;
  endtask
  task automatic chk_cfg;
    chk("settings out", 8'(set_m & 'h7F), {1'b0, tlm, ptmo, pmode});
    chk("thermal out", 8'(thr_m), {3'b000, hyst, thr});
  endtask
  // hang guard: the whole sequence needs about 2230 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdr(16'h2000); chk("settings", 8'h22, q);
    rdr(16'h2001); chk("thermal", 8'h1A, q);
    rd_sts(1'b0);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wrr(16'h2000, d); set_m = d & 8'h7F;
      wrr(16'h2001, ~d); thr_m = ~d & 8'h1F;
      rdr(16'h2000); chk("settings", 8'(set_m), q);
      rdr(16'h2001); chk("thermal", 8'(thr_m), q);
      chk_cfg;
    end
    $display("test config done");
    for (int m = 0; m < 3; m++) begin
      wrr(16'h2000, 8'(m)); set_m = m;
      @(posedge clk_i); recal_i <= 1'($random(seed));
      @(posedge clk_i);
      rd_sts(m != 0);
    end
    @(posedge clk_i); act_i <= 1'b1;
    rd_sts(1'b0);
    wrr(16'h2000, 8'h06); set_m = 'h06;
    @(posedge clk_i); act_i <= 1'b0;
    rd_sts(1'b0);
    repeat (512 * CPM) @(posedge clk_i);
    rd_sts(1'b1);
    wrr(16'h2000, 8'h40); set_m = 'h40;
    $display("test power done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i); ot_i <= !k; oc_i <= k;
      @(posedge clk_i); ot_i <= 1'b0; oc_i <= 1'b0;
      ot_m = !k; oc_m = k;
      rd_sts(1'b0);
      rd_sts(1'b0);
    end
    // a fault that lands in the very cycle of a status read must survive that read
    fork
      rd_sts(1'b0);
      begin
        @(posedge clk_i); ot_i <= 1'b1;
        @(posedge clk_i); ot_i <= 1'b0;
      end
    join
    ot_m = 1;
    rd_sts(1'b0);
    rd_sts(1'b0);
    $display("test faults done");
    foreach (hc[i]) begin
      wrr(16'h2003, hc[i]);
      chk("trigger", {7'h00, hc[i][1:0] == 2'b01}, {7'h00, trig});
      chk("stop", {7'h00, hc[i][1]}, {7'h00, stop});
      @(posedge clk_i);
      #1 chk("pulse end", 8'h00, {6'h00, trig, stop});
      rdr(16'h2003); chk("haptic ctrl", 8'h00, q);
    end
    $display("test haptic control done");
    wrr(16'h2002, 8'h01); rf_m = 0;
    rd_sts(1'b0);
    wrr(16'h2002, 8'h00); chk_cfg;
    rdr(16'h2002); chk("system ctrl", 8'h00, q);
    wrr(16'h2002, 8'h02); rf_m = 1; set_m = 'h22; thr_m = 'h1A;
    chk("soft reset", 8'h01, {7'h00, srst});
    chk_cfg;
    rd_sts(1'b0);
    wrr(16'h2002, 8'h03);
    rd_sts(1'b0);
    wrr(16'h2002, 8'h01); rf_m = 0;
    wrr(16'h1000, 8'hFF);
    rd_sts(1'b0);
    // a low clock enable must freeze the bank and ignore the host
    @(posedge clk_i); ce_i <= 1'b0;
    wrr(16'h2000, 8'h15);
    chk("frozen settings", 8'h22, {1'b0, tlm, ptmo, pmode});
    @(posedge clk_i); ce_i <= 1'b1;
    rdr(16'h2000); chk("settings", 8'h22, q);
    rdr(16'h3000); chk("unmapped", 8'hEE, q);
    $display("test system control done");
    print_verdict;
  end
endmodule
